// ===== ufc_pkg.sv
package ufc_pkg;
   localparam logic [7:0] IDX_CTRL = 8'h98;
   localparam logic [7:0] IDX_DATA = 8'h99;
   localparam logic [7:0] IDX_MODE = 8'ha9;
   localparam logic [7:0] IDX_BAUD = 8'hac;
   localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
   localparam logic [11:0] A_DATA = {2'h0, IDX_DATA, 2'h0};
   localparam logic [11:0] A_MODE = {2'h0, IDX_MODE, 2'h0};
   localparam logic [11:0] A_BAUD = {2'h0, IDX_BAUD, 2'h0};
   localparam logic [7:0] MODE_RST = 8'h0c;
   localparam logic [7:0] CTRL_RST = 8'h20;
   localparam logic [15:0] BAUD_RST = 16'h0364;
   localparam logic [1:0] PT_ODD = 2'h0;
   localparam logic [1:0] PT_EVEN = 2'h1;
   localparam logic [1:0] PT_MARK = 2'h2;
   localparam logic [1:0] DL_5 = 2'h0;
   localparam logic [7:0] HI_MASK5 = 8'he0;
   localparam logic [2:0] LAST_BASE = 3'h4;
   localparam logic [2:0] HU_HALF = 3'h1;
   localparam logic [2:0] HU_BIT = 3'h2;
   localparam logic [2:0] HU_STOP15 = 3'h3;
   localparam logic [2:0] HU_STOP2 = 3'h4;
   localparam int FIFO_AW = 1;
   typedef struct packed {
      logic mce;
      logic [1:0] ptype;
      logic pe;
      logic [1:0] dlen;
      logic xbe;
      logic sbl;
   } ufc_mode_t;
   typedef struct packed {
      logic ovr;
      logic perr;
      logic thre;
      logic ren;
      logic tbx;
      logic rbx;
      logic ti;
      logic ri;
   } ufc_ctrl_t;
   typedef struct packed {
      logic perr;
      logic [7:0] data;
   } ufc_rx_t;
   typedef enum logic [4:0] {
      SER_IDLE = 5'h01,
      SER_START = 5'h02,
      SER_DATA = 5'h04,
      SER_XTRA = 5'h08,
      SER_STOP = 5'h10
   } ufc_ser_t;
endpackage

// ===== ufc_rx_fifo.sv
`timescale 1ns/1ps
module ufc_rx_fifo (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write side
   input wire logic push,
   input wire ufc_pkg::ufc_rx_t push_data,
   output logic full,
   // read side
   input wire logic pop,
   output ufc_pkg::ufc_rx_t pop_data,
   output logic empty
);
   localparam int AW = ufc_pkg::FIFO_AW;
   localparam int DEPTH = 2 ** AW;
   ufc_pkg::ufc_rx_t mem_r [DEPTH];
   ufc_pkg::ufc_rx_t mem_nxt [DEPTH];
   ufc_pkg::ufc_rx_t pop_data_r, pop_data_nxt;
   logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;

   assign empty = wr_r == rd_r;
   assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
   assign pop_data = pop_data_r;

   always_comb begin
      mem_nxt = mem_r;
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      pop_data_nxt = pop_data_r;
      if (push && !full) begin
         mem_nxt[wr_r[AW-1:0]] = push_data;
         wr_nxt = wr_r + 1'b1;
      end
      if (pop && !empty) begin
         pop_data_nxt = mem_r[rd_r[AW-1:0]];
         rd_nxt = rd_r + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_r <= '{default: '0};
         wr_r <= '0;
         rd_r <= '0;
         pop_data_r <= '0;
      end else begin
         mem_r <= mem_nxt;
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         pop_data_r <= pop_data_nxt;
      end
   end
endmodule // ufc_rx_fifo

// ===== ufc_uart.sv
`timescale 1ns/1ps
module ufc_uart (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line
   input wire logic rxd,
   output logic txd,
   // interrupt
   input wire logic uart_int_en,
   output logic uart_irq
);
   ufc_pkg::ufc_mode_t mode_r, mode_nxt;
   ufc_pkg::ufc_ctrl_t ctrl_r, ctrl_nxt, wctl;
   logic [15:0] baud_r, baud_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic irq_r, irq_nxt;
   logic setup, wr_acc, rd_acc, mapped, buf_rd, tx_load;
   logic [14:0] half_m1;
   logic [2:0] last_bit, stop_units;
   logic has_x;
   // transmitter
   ufc_pkg::ufc_ser_t tx_st_r, tx_st_nxt;
   logic [7:0] tx_sh_r, tx_sh_nxt;
   logic [2:0] tx_bit_r, tx_bit_nxt, tx_u_r, tx_u_nxt, tx_tgt;
   logic [14:0] tx_h_r, tx_h_nxt;
   logic txd_r, txd_nxt, tx_tick, tx_done, tx_stop_evt, tx_xval;
   // receiver
   ufc_pkg::ufc_ser_t rx_st_r, rx_st_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt;
   logic [2:0] rx_bit_r, rx_bit_nxt, rx_u_r, rx_u_nxt, rx_tgt;
   logic [14:0] rx_h_r, rx_h_nxt;
   logic rx_x_r, rx_x_nxt, rx_tick, rx_done, rx_s1_r, rx_s2_r;
   logic rbx_val, rx_pass, rx_push, rx_ovr;
   // receive queue and latch
   ufc_pkg::ufc_rx_t rx_head, rx_entry;
   logic fifo_full, fifo_empty, pop, lat_v_r, lat_v_nxt, pop_q_r, pop_q_nxt;

   function automatic logic par_of(input logic [7:0] d, input ufc_pkg::ufc_mode_t m);
      logic [7:0] dm;
      dm = d & ~(ufc_pkg::HI_MASK5 << m.dlen);
      case (m.ptype)
         ufc_pkg::PT_ODD: par_of = ~^dm;
         ufc_pkg::PT_EVEN: par_of = ^dm;
         ufc_pkg::PT_MARK: par_of = 1'b1;
         default: par_of = 1'b0;
      endcase
   endfunction

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign mapped = (paddr == ufc_pkg::A_CTRL) || (paddr == ufc_pkg::A_DATA) ||
                   (paddr == ufc_pkg::A_MODE) || (paddr == ufc_pkg::A_BAUD);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_r;
   assign txd = txd_r;
   assign uart_irq = irq_r;
   assign buf_rd = rd_acc && (paddr == ufc_pkg::A_DATA);
   assign tx_load = wr_acc && (paddr == ufc_pkg::A_DATA) && (tx_st_r == ufc_pkg::SER_IDLE);
   assign wctl = ufc_pkg::ufc_ctrl_t'(pwdata[7:0]);
   assign half_m1 = (baud_r[15:1] == 15'h0) ? 15'h0 : baud_r[15:1] - 15'h1;
   assign last_bit = ufc_pkg::LAST_BASE + {1'b0, mode_r.dlen};
   assign has_x = mode_r.xbe || mode_r.pe;
   assign stop_units = !mode_r.sbl ? ufc_pkg::HU_BIT :
                       (mode_r.dlen == ufc_pkg::DL_5) ? ufc_pkg::HU_STOP15 : ufc_pkg::HU_STOP2;
   assign tx_xval = mode_r.pe ? par_of(tx_sh_r, mode_r) : ctrl_r.tbx;

   // register file and flags
   always_comb begin
      mode_nxt = mode_r;
      ctrl_nxt = ctrl_r;
      baud_nxt = baud_r;
      prdata_nxt = prdata_r;
      if (setup) begin
         case (paddr)
            ufc_pkg::A_CTRL: prdata_nxt = {24'h0, ctrl_r};
            ufc_pkg::A_DATA: prdata_nxt = {24'h0, rx_head.data};
            ufc_pkg::A_MODE: prdata_nxt = {24'h0, mode_r};
            ufc_pkg::A_BAUD: prdata_nxt = {16'h0, baud_r};
            default: prdata_nxt = 32'h0;
         endcase
      end
      if (wr_acc) begin
         case (paddr)
            ufc_pkg::A_MODE: mode_nxt = ufc_pkg::ufc_mode_t'(pwdata[7:0]);
            ufc_pkg::A_BAUD: baud_nxt = pwdata[15:0];
            ufc_pkg::A_CTRL: begin
               ctrl_nxt = wctl;
               ctrl_nxt.thre = ctrl_r.thre;
            end
            default: ;
         endcase
      end
      ctrl_nxt.ri = ctrl_nxt.ri || !fifo_empty;
      if (tx_stop_evt) begin
         ctrl_nxt.ti = 1'b1;
      end
      if (rx_push) begin
         ctrl_nxt.ri = 1'b1;
      end
      if (rx_ovr) begin
         ctrl_nxt.ovr = 1'b1;
      end
      if (pop_q_r && rx_head.perr) begin
         ctrl_nxt.perr = 1'b1;
      end
      if (rx_done) begin
         ctrl_nxt.rbx = rbx_val;
      end
      ctrl_nxt.thre = (tx_st_nxt == ufc_pkg::SER_IDLE);
      irq_nxt = uart_int_en && (ctrl_nxt.ti || ctrl_nxt.ri);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= ufc_pkg::MODE_RST;
         ctrl_r <= ufc_pkg::CTRL_RST;
         baud_r <= ufc_pkg::BAUD_RST;
         prdata_r <= 32'h0;
         irq_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         ctrl_r <= ctrl_nxt;
         baud_r <= baud_nxt;
         prdata_r <= prdata_nxt;
         irq_r <= irq_nxt;
      end
   end

   // transmitter
   always_comb begin
      tx_st_nxt = tx_st_r;
      tx_sh_nxt = tx_sh_r;
      tx_bit_nxt = tx_bit_r;
      tx_h_nxt = tx_h_r;
      tx_u_nxt = tx_u_r;
      tx_stop_evt = 1'b0;
      tx_tgt = (tx_st_r == ufc_pkg::SER_STOP) ? stop_units : ufc_pkg::HU_BIT;
      tx_tick = tx_h_r == half_m1;
      tx_done = tx_tick && ((tx_u_r + 3'h1) == tx_tgt);
      if (tx_st_r != ufc_pkg::SER_IDLE) begin
         tx_h_nxt = tx_tick ? 15'h0 : tx_h_r + 15'h1;
         tx_u_nxt = tx_done ? 3'h0 : (tx_tick ? tx_u_r + 3'h1 : tx_u_r);
      end
      case (tx_st_r)
         ufc_pkg::SER_IDLE: begin
            if (tx_load) begin
               tx_st_nxt = ufc_pkg::SER_START;
               tx_sh_nxt = pwdata[7:0];
               tx_bit_nxt = 3'h0;
               tx_h_nxt = 15'h0;
               tx_u_nxt = 3'h0;
            end
         end
         ufc_pkg::SER_START: begin
            if (tx_done) begin
               tx_st_nxt = ufc_pkg::SER_DATA;
            end
         end
         ufc_pkg::SER_DATA: begin
            if (tx_done) begin
               if (tx_bit_r == last_bit) begin
                  if (has_x) begin
                     tx_st_nxt = ufc_pkg::SER_XTRA;
                  end else begin
                     tx_st_nxt = ufc_pkg::SER_STOP;
                     tx_stop_evt = 1'b1;
                  end
               end else begin
                  tx_bit_nxt = tx_bit_r + 3'h1;
               end
            end
         end
         ufc_pkg::SER_XTRA: begin
            if (tx_done) begin
               tx_st_nxt = ufc_pkg::SER_STOP;
               tx_stop_evt = 1'b1;
            end
         end
         ufc_pkg::SER_STOP: begin
            if (tx_done) begin
               tx_st_nxt = ufc_pkg::SER_IDLE;
            end
         end
         default: tx_st_nxt = ufc_pkg::SER_IDLE;
      endcase
      case (tx_st_nxt)
         ufc_pkg::SER_START: txd_nxt = 1'b0;
         ufc_pkg::SER_DATA: txd_nxt = tx_sh_nxt[tx_bit_nxt];
         ufc_pkg::SER_XTRA: txd_nxt = tx_xval;
         default: txd_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_r <= ufc_pkg::SER_IDLE;
         tx_sh_r <= 8'h0;
         tx_bit_r <= 3'h0;
         tx_h_r <= 15'h0;
         tx_u_r <= 3'h0;
         txd_r <= 1'b1;
      end else begin
         tx_st_r <= tx_st_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_h_r <= tx_h_nxt;
         tx_u_r <= tx_u_nxt;
         txd_r <= txd_nxt;
      end
   end

   // receiver; rx_s2_r is the synchronised line
   assign rbx_val = mode_r.xbe ? rx_x_r : rx_s2_r;
   assign rx_pass = rx_s2_r && (!mode_r.mce || rbx_val);
   assign rx_push = rx_done && rx_pass && !fifo_full;
   assign rx_ovr = rx_done && rx_pass && fifo_full;

   always_comb begin
      rx_st_nxt = rx_st_r;
      rx_sh_nxt = rx_sh_r;
      rx_bit_nxt = rx_bit_r;
      rx_h_nxt = rx_h_r;
      rx_u_nxt = rx_u_r;
      rx_x_nxt = rx_x_r;
      rx_done = 1'b0;
      rx_tgt = (rx_st_r == ufc_pkg::SER_START) ? ufc_pkg::HU_HALF : ufc_pkg::HU_BIT;
      rx_tick = rx_h_r == half_m1;
      if (rx_st_r != ufc_pkg::SER_IDLE) begin
         rx_h_nxt = rx_tick ? 15'h0 : rx_h_r + 15'h1;
         rx_u_nxt = (rx_tick && ((rx_u_r + 3'h1) == rx_tgt)) ? 3'h0 : (rx_tick ? rx_u_r + 3'h1 : rx_u_r);
      end
      case (rx_st_r)
         ufc_pkg::SER_IDLE: begin
            if (ctrl_r.ren && !rx_s2_r) begin
               rx_st_nxt = ufc_pkg::SER_START;
               rx_sh_nxt = 8'h0;
               rx_bit_nxt = 3'h0;
               rx_h_nxt = 15'h0;
               rx_u_nxt = 3'h0;
            end
         end
         ufc_pkg::SER_START: begin
            if (rx_tick && ((rx_u_r + 3'h1) == rx_tgt)) begin
               rx_st_nxt = rx_s2_r ? ufc_pkg::SER_IDLE : ufc_pkg::SER_DATA;
            end
         end
         ufc_pkg::SER_DATA: begin
            if (rx_tick && ((rx_u_r + 3'h1) == rx_tgt)) begin
               rx_sh_nxt[rx_bit_r] = rx_s2_r;
               rx_bit_nxt = rx_bit_r + 3'h1;
               if (rx_bit_r == last_bit) begin
                  rx_st_nxt = has_x ? ufc_pkg::SER_XTRA : ufc_pkg::SER_STOP;
               end
            end
         end
         ufc_pkg::SER_XTRA: begin
            if (rx_tick && ((rx_u_r + 3'h1) == rx_tgt)) begin
               rx_x_nxt = rx_s2_r;
               rx_st_nxt = ufc_pkg::SER_STOP;
            end
         end
         ufc_pkg::SER_STOP: begin
            if (rx_tick && ((rx_u_r + 3'h1) == rx_tgt)) begin
               rx_done = 1'b1;
               rx_st_nxt = ufc_pkg::SER_IDLE;
            end
         end
         default: rx_st_nxt = ufc_pkg::SER_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_r <= ufc_pkg::SER_IDLE;
         rx_sh_r <= 8'h0;
         rx_bit_r <= 3'h0;
         rx_h_r <= 15'h0;
         rx_u_r <= 3'h0;
         rx_x_r <= 1'b0;
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_st_r <= rx_st_nxt;
         rx_sh_r <= rx_sh_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_h_r <= rx_h_nxt;
         rx_u_r <= rx_u_nxt;
         rx_x_r <= rx_x_nxt;
         rx_s1_r <= rxd;
         rx_s2_r <= rx_s1_r;
      end
   end

   // queue to latch; latch refills after a buffer read
   assign pop = !fifo_empty && (!lat_v_r || buf_rd);

   always_comb begin
      pop_q_nxt = pop;
      lat_v_nxt = lat_v_r;
      if (pop) begin
         lat_v_nxt = 1'b1;
      end else if (buf_rd) begin
         lat_v_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pop_q_r <= 1'b0;
         lat_v_r <= 1'b0;
      end else begin
         pop_q_r <= pop_q_nxt;
         lat_v_r <= lat_v_nxt;
      end
   end

   assign rx_entry.perr = mode_r.pe && (rx_x_r != par_of(rx_sh_r, mode_r));
   assign rx_entry.data = rx_sh_r;

   ufc_rx_fifo u_rx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .push(rx_push),
      .push_data(rx_entry),
      .full(fifo_full),
      .pop(pop),
      .pop_data(rx_head),
      .empty(fifo_empty)
   );
endmodule // ufc_uart

// ===== ufc_uart_monitor.sv
`timescale 1ns/1ps
module ufc_uart_monitor (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // serial and interrupt
   input wire logic rxd,
   input wire logic txd,
   input wire logic uart_int_en,
   input wire logic uart_irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   irq_masked_a: assert property (!$past(uart_int_en) |-> !uart_irq)
      else $error("interrupt raised while masked");
   irq_held_a: assert property (uart_irq && uart_int_en && !(psel && penable && pwrite) |=> uart_irq)
      else $error("interrupt dropped without a write");
   start_len_a: assert property ($fell(txd) |=> !txd)
      else $error("start bit shorter than two cycles");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access phase");
   err_data_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   ready_now_a: assert property (psel && penable |-> pready)
      else $error("wait state inserted");
   upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0)
      else $error("read data upper half not zero");
   mode_ok_a: assert property (psel && penable && paddr == ufc_pkg::A_MODE |-> !pslverr && prdata[31:8] == 24'h0)
      else $error("frame mode access faulted");
endmodule // ufc_uart_monitor

bind ufc_uart ufc_uart_monitor u_mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rxd(rxd), .txd(txd), .uart_int_en(uart_int_en), .uart_irq(uart_irq));

// ===== ufc_serial_peer.sv
`timescale 1ns/1ps
module ufc_serial_peer #(
   parameter int BT = 4
) (
   // clock
   input wire logic pclk,
   // serial line
   input wire logic txd,
   output logic rxd
);
   initial rxd = 1'b1;
   task automatic send(input logic [8:0] bits, input int n, input logic stp);
      rxd <= 1'b0;
      repeat (BT) @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         rxd <= bits[i];
         repeat (BT) @(posedge pclk);
      end
      rxd <= stp;
      repeat (BT) @(posedge pclk);
      rxd <= 1'b1;
      repeat (2 * BT) @(posedge pclk);
   endtask
   task automatic recv(input int c, output logic [10:0] bits);
      bits = 11'h7ff;
      while (txd !== 1'b0) @(negedge pclk);
      repeat (BT / 2) @(negedge pclk);
      for (int i = 0; i < c; i++) begin
         bits[i] = txd;
         repeat (BT) @(negedge pclk);
      end
   endtask
endmodule // ufc_serial_peer

// ===== ufc_uart_tb_top.sv
`timescale 1ns/1ps
module ufc_uart_tb_top;
   localparam int BT = 4;
   localparam logic [11:0] AM = ufc_pkg::A_MODE;
   localparam logic [11:0] AC = ufc_pkg::A_CTRL;
   localparam logic [11:0] AD = ufc_pkg::A_DATA;
   localparam logic [7:0] MT [7] = '{8'h0c, 8'h11, 8'h34, 8'h58, 8'h7c, 8'h0e, 8'h7e};
   localparam logic [7:0] RM [6] = '{8'h0e, 8'h0c, 8'h8e, 8'h8e, 8'h0c, 8'h0c};
   localparam logic [7:0] RC [6] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h00, 8'h10};
   localparam logic [8:0] RB [6] = '{9'h13c, 9'h0a5, 9'h03c, 9'h13c, 9'h0a5, 9'h1a5};
   localparam logic RS [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
   localparam logic RE [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic uart_int_en = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rxd;
   logic txd;
   logic uart_irq;
   logic [31:0] q;
   logic [10:0] got;
   logic [7:0] m;
   int bad_count = 0;
   int n_checks = 0;
   always #5 pclk = ~pclk;
   ufc_uart u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxd(rxd), .txd(txd), .uart_int_en(uart_int_en), .uart_irq(uart_irq));
   ufc_serial_peer #(.BT(BT)) u_peer (.pclk(pclk), .txd(txd), .rxd(rxd));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never re-drives psel in this time step
      @(posedge pclk);
   endtask
   function automatic logic [10:0] frame(input logic [7:0] md, input logic [7:0] d, input logic tbx);
      logic [10:0] f;
      logic p;
      int n;
      n = int'(md[3:2]) + 5;
      f = 11'h7fe;
      p = 1'b0;
      for (int i = 0; i < n; i++) begin
         f[i + 1] = d[i];
         p = p ^ d[i];
      end
      if (md[4] | md[1]) begin
         f[n + 1] = md[4] ? (md[6] ? ~md[5] : p ^ ~md[5]) : tbx;
      end
      return f;
   endfunction
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      close_out;
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(AM, 1'b0, 32'h0);
      chk(q, 32'h0c);
      apb(AC, 1'b0, 32'h0);
      chk(q, 32'h20);
      apb(12'h004, 1'b0, 32'h0);
      chk(q, 32'h0);
      apb(ufc_pkg::A_BAUD, 1'b1, 32'h4);
      $display("register test done");
      for (int i = 0; i < 7; i++) begin
         m = MT[i];
         apb(AM, 1'b1, {24'h0, m});
         apb(AC, 1'b1, (i > 4) ? 32'h18 : 32'h10);
         uart_int_en <= (i != 0);
         apb(AD, 1'b1, 32'hb5);
         u_peer.recv(int'(m[3:2]) + 7 + int'(m[4] | m[1]), got);
         chk({21'h0, got}, {21'h0, frame(m, 8'hb5, i > 4)});
         repeat (3 * BT) @(posedge pclk);
         apb(AC, 1'b0, 32'h0);
         chk(q & 32'h2, 32'h2);
         chk({31'h0, uart_irq}, (i != 0) ? 32'h1 : 32'h0);
      end
      apb(AC, 1'b1, 32'h10);
      apb(AC, 1'b0, 32'h0);
      chk(q & 32'h3, 32'h0);
      $display("transmit test done");
      for (int i = 0; i < 6; i++) begin
         apb(AM, 1'b1, {24'h0, RM[i]});
         apb(AC, 1'b1, {24'h0, RC[i]});
         u_peer.send(RB[i], RM[i][1] ? 9 : 8, RS[i]);
         apb(AC, 1'b0, 32'h0);
         chk(q & 32'h1, {31'h0, RE[i]});
         if (RE[i]) begin
            chk(q & 32'h4, {29'h0, RB[i][8], 2'h0});
            apb(AD, 1'b0, 32'h0);
            chk(q, {24'h0, RB[i][7:0]});
            apb(AC, 1'b1, 32'h10);
            apb(AC, 1'b0, 32'h0);
            chk(q & 32'h1, 32'h0);
         end
      end
      $display("receive test done");
      apb(AM, 1'b1, 32'h1c);
      u_peer.send(9'h101, 9, 1'b1);
      apb(AD, 1'b0, 32'h0);
      apb(AC, 1'b0, 32'h0);
      chk(q & 32'h40, 32'h40);
      apb(AM, 1'b1, 32'h0c);
      apb(AC, 1'b1, 32'h10);
      repeat (4) u_peer.send(9'h0a5, 8, 1'b1);
      apb(AC, 1'b0, 32'h0);
      chk(q & 32'hc1, 32'h81);
      apb(AC, 1'b1, 32'h10);
      apb(AC, 1'b0, 32'h0);
      chk(q & 32'hc1, 32'h01);
      $display("error test done");
      close_out;
   end
endmodule // ufc_uart_tb_top
